//--- rtl/mal_pkg.sv
package mal_pkg;

	// ---------------------------------------------------------------
	// Register map (byte addresses, one word each)
	// ---------------------------------------------------------------
	localparam logic [7:0] ADR_ACC    = 8'h00;
	localparam logic [7:0] ADR_FLAGS  = 8'h04;
	localparam logic [7:0] ADR_MULOP  = 8'h08;
	localparam logic [7:0] ADR_MULRH  = 8'h0C;
	localparam logic [7:0] ADR_STATUS = 8'h10;

	// ---------------------------------------------------------------
	// Field positions and reset values
	// ---------------------------------------------------------------
	localparam int FLG_ZERO  = 0;
	localparam int FLG_CARRY = 1;
	localparam int FLG_HALF  = 2;
	localparam int FLG_OVF   = 3;
	localparam int FLG_W     = 4;
	localparam int STS_BUSY  = 0;
	localparam int STS_OP_LO = 8;
	localparam int NIB_W     = 4;

	localparam logic [7:0]  RST_BYTE  = 8'h00;
	localparam logic [3:0]  RST_FLAGS = 4'h0;
	localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
	localparam logic [7:0]  BYTE_ONE  = 8'h01;

	// ---------------------------------------------------------------
	// Operations and sequencer states
	// ---------------------------------------------------------------
	typedef enum logic [4:0] {
		OP_ADD, OP_ADDC, OP_ADDC1, OP_NADD, OP_SUB, OP_SUBC,
		OP_SUBC1, OP_INC, OP_DEC, OP_CLR, OP_MUL, OP_SR, OP_SRC,
		OP_SL, OP_SLC, OP_SWAP, OP_AND, OP_OR, OP_XOR, OP_XORIO,
		OP_NOT, OP_NEG, OP_CMP
	} mal_op_t;

	typedef enum logic [1:0] {
		ST_IDLE, ST_EXEC, ST_WRITE
	} mal_state_t;

endpackage : mal_pkg

//--- rtl/mal_alu.sv
// The implementer's own choices: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module mal_alu #(
	parameter int ADDR_W = 7
) (
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	// Wishbone classic slave
	input  wire logic [7:0]        wb_adr_i,
	input  wire logic [31:0]       wb_dat_i,
	output logic      [31:0]       wb_dat_o,
	input  wire logic              wb_we_i,
	input  wire logic [3:0]        wb_sel_i,
	input  wire logic              wb_stb_i,
	input  wire logic              wb_cyc_i,
	output logic                   wb_ack_o,
	// Instruction request from the sequencer
	input  wire logic              exec_valid_i,
	input  wire logic [4:0]        exec_op_i,
	input  wire logic              exec_dst_mem_i,
	input  wire logic              exec_src_imm_i,
	input  wire logic [ADDR_W-1:0] exec_addr_i,
	input  wire logic [7:0]        exec_imm_i,
	output logic                   exec_ready_o,
	output logic                   exec_done_o,
	// Data memory port
	output logic      [ADDR_W-1:0] mem_addr_o,
	input  wire logic [7:0]        mem_rdata_i,
	output logic                   mem_we_o,
	output logic      [7:0]        mem_wdata_o,
	// IO register port
	input  wire logic [7:0]        io_rdata_i,
	output logic                   io_we_o,
	output logic      [7:0]        io_wdata_o
);

	// ---------------------------------------------------------------
	// Elaboration checks
	// ---------------------------------------------------------------
	if (ADDR_W < 1 || ADDR_W > 8) begin : g_bad_addr_w
		$error("mal_alu: ADDR_W must be 1 to 8");
	end

	// ---------------------------------------------------------------
	// Adder helper
	// ---------------------------------------------------------------
	// Returns {ovf, half, carry, result}; sub turns carries to borrows
	function automatic logic [10:0] mal_arith(
		input logic [7:0] a,
		input logic [7:0] b,
		input logic       cin,
		input logic       sub
	);
		logic [7:0] bb;
		logic       ci;
		logic [4:0] lo;
		logic [8:0] full;
		logic       ov;
		bb   = sub ? ~b : b;
		ci   = sub ? ~cin : cin;
		lo   = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, ci};
		full = {1'b0, a} + {1'b0, bb} + {8'h00, ci};
		// Signed range exceeded when like signs give unlike result
		ov   = (a[7] == bb[7]) && (full[7] != a[7]);
		// Borrow is the inverted carry on subtraction
		mal_arith = {ov, lo[mal_pkg::NIB_W] ^ sub,
			full[8] ^ sub, full[7:0]};
	endfunction : mal_arith

	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	mal_pkg::mal_state_t        state_q;
	mal_pkg::mal_state_t        state_d;
	mal_pkg::mal_op_t           op_q;
	logic                       dst_mem_q;
	logic                       src_imm_q;
	logic [ADDR_W-1:0]          addr_q;
	logic [7:0]                 imm_q;
	logic [7:0]                 acc_q;
	logic [7:0]                 mulop_q;
	logic [7:0]                 mulrh_q;
	logic [mal_pkg::FLG_W-1:0]  flags_q;
	logic [7:0]                 wdata_q;
	logic                       io_pend_q;
	logic                       done_q;
	logic                       ack_q;
	logic [31:0]                rdat_q;

	// ---------------------------------------------------------------
	// Operand selection
	// ---------------------------------------------------------------
	// Destination is the operand that receives the result
	wire        take     = exec_valid_i && (state_q == mal_pkg::ST_IDLE);
	wire        exec_now = (state_q == mal_pkg::ST_EXEC);
	wire [7:0]  dst_val  = dst_mem_q ? mem_rdata_i : acc_q;
	wire [7:0]  oth_val  = dst_mem_q ? acc_q : mem_rdata_i;
	wire [7:0]  src_val  = src_imm_q ? imm_q : oth_val;
	wire        c_in     = flags_q[mal_pkg::FLG_CARRY];
	wire [15:0] product  = {8'h00, acc_q} * {8'h00, mulop_q};

	// ---------------------------------------------------------------
	// Result and flag computation
	// ---------------------------------------------------------------
	logic [7:0]  res;
	logic [10:0] ar;
	logic        use_ar;
	logic        wr_dst;
	logic        wr_io;
	logic        wr_mul;
	logic        upd_z;
	logic        upd_c;
	logic        upd_hv;
	logic        new_c;

	// One decoder for every operation; arithmetic except NEG and MUL funnels to mal_arith
	always_comb begin
		res    = dst_val;
		ar     = mal_arith(dst_val, src_val, 1'b0, 1'b0);
		use_ar = 1'b0;
		wr_dst = 1'b1;
		wr_io  = 1'b0;
		wr_mul = 1'b0;
		upd_z  = 1'b0;
		upd_c  = 1'b0;
		upd_hv = 1'b0;
		new_c  = c_in;
		case (op_q)
			mal_pkg::OP_ADD: begin
				use_ar = 1'b1;
			end
			mal_pkg::OP_ADDC: begin
				ar     = mal_arith(dst_val, src_val, c_in, 1'b0);
				use_ar = 1'b1;
			end
			mal_pkg::OP_ADDC1: begin
				ar     = mal_arith(dst_val, mal_pkg::RST_BYTE, c_in,
					1'b0);
				use_ar = 1'b1;
			end
			mal_pkg::OP_NADD: begin
				// Negated destination plus other: s + ~d + 1
				ar     = mal_arith(src_val, ~dst_val, 1'b1, 1'b0);
				use_ar = 1'b1;
			end
			mal_pkg::OP_SUB: begin
				ar     = mal_arith(dst_val, src_val, 1'b0, 1'b1);
				use_ar = 1'b1;
			end
			mal_pkg::OP_SUBC: begin
				ar     = mal_arith(dst_val, src_val, c_in, 1'b1);
				use_ar = 1'b1;
			end
			mal_pkg::OP_SUBC1: begin
				ar     = mal_arith(dst_val, mal_pkg::RST_BYTE, c_in,
					1'b1);
				use_ar = 1'b1;
			end
			mal_pkg::OP_INC: begin
				ar     = mal_arith(dst_val, mal_pkg::BYTE_ONE, 1'b0,
					1'b0);
				use_ar = 1'b1;
			end
			mal_pkg::OP_DEC: begin
				ar     = mal_arith(dst_val, mal_pkg::BYTE_ONE, 1'b0,
					1'b1);
				use_ar = 1'b1;
			end
			mal_pkg::OP_CLR: begin
				res = mal_pkg::RST_BYTE;
			end
			mal_pkg::OP_MUL: begin
				wr_dst = 1'b0;
				wr_mul = 1'b1;
			end
			mal_pkg::OP_SR: begin
				res   = {1'b0, dst_val[7:1]};
				upd_c = 1'b1;
				new_c = dst_val[0];
			end
			mal_pkg::OP_SRC: begin
				res   = {c_in, dst_val[7:1]};
				upd_c = 1'b1;
				new_c = dst_val[0];
			end
			mal_pkg::OP_SL: begin
				res   = {dst_val[6:0], 1'b0};
				upd_c = 1'b1;
				new_c = dst_val[7];
			end
			mal_pkg::OP_SLC: begin
				res   = {dst_val[6:0], c_in};
				upd_c = 1'b1;
				new_c = dst_val[7];
			end
			mal_pkg::OP_SWAP: begin
				res = {dst_val[3:0], dst_val[7:4]};
			end
			mal_pkg::OP_AND: begin
				res   = dst_val & src_val;
				upd_z = 1'b1;
			end
			mal_pkg::OP_OR: begin
				res   = dst_val | src_val;
				upd_z = 1'b1;
			end
			mal_pkg::OP_XOR: begin
				res   = dst_val ^ src_val;
				upd_z = 1'b1;
			end
			mal_pkg::OP_XORIO: begin
				res    = acc_q ^ io_rdata_i;
				wr_dst = 1'b0;
				wr_io  = 1'b1;
			end
			mal_pkg::OP_NOT: begin
				res   = ~dst_val;
				upd_z = 1'b1;
			end
			mal_pkg::OP_NEG: begin
				res   = ~dst_val + mal_pkg::BYTE_ONE;
				upd_z = 1'b1;
			end
			mal_pkg::OP_CMP: begin
				ar     = mal_arith(dst_val, src_val, 1'b0, 1'b1);
				use_ar = 1'b1;
				wr_dst = 1'b0;
			end
			default: begin
				wr_dst = 1'b0;
			end
		endcase
		if (use_ar) begin
			res    = ar[7:0];
			upd_z  = 1'b1;
			upd_c  = 1'b1;
			upd_hv = 1'b1;
			new_c  = ar[8];
		end
	end

	// Zero flag follows the result of any op that updates it
	wire z_new = (res == mal_pkg::RST_BYTE);

	// Memory write-back needs a second cycle on the same address
	wire to_mem = wr_dst && dst_mem_q;

	// ---------------------------------------------------------------
	// Sequencer
	// ---------------------------------------------------------------
	// Address stays in addr_q from read to write-back, nothing between
	always_comb begin
		state_d = state_q;
		case (state_q)
			mal_pkg::ST_IDLE: begin
				if (take) begin
					state_d = mal_pkg::ST_EXEC;
				end
			end
			mal_pkg::ST_EXEC: begin
				state_d = to_mem ? mal_pkg::ST_WRITE
					: mal_pkg::ST_IDLE;
			end
			mal_pkg::ST_WRITE: begin
				state_d = mal_pkg::ST_IDLE;
			end
			default: begin
				state_d = mal_pkg::ST_IDLE;
			end
		endcase
	end

	// State register and request latch
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_q   <= mal_pkg::ST_IDLE;
			op_q      <= mal_pkg::OP_CLR;
			dst_mem_q <= 1'b0;
			src_imm_q <= 1'b0;
			addr_q    <= '0;
			imm_q     <= mal_pkg::RST_BYTE;
		end else begin
			state_q <= state_d;
			if (take) begin
				op_q      <= mal_pkg::mal_op_t'(exec_op_i);
				dst_mem_q <= exec_dst_mem_i;
				src_imm_q <= exec_src_imm_i;
				addr_q    <= exec_addr_i;
				imm_q     <= exec_imm_i;
			end
		end
	end

	// Write-back data, IO strobe and completion pulse
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wdata_q   <= mal_pkg::RST_BYTE;
			io_pend_q <= 1'b0;
			done_q    <= 1'b0;
		end else begin
			io_pend_q <= exec_now && wr_io;
			done_q    <= exec_now && !to_mem
				|| (state_q == mal_pkg::ST_WRITE);
			if (exec_now) begin
				wdata_q <= res;
			end
		end
	end

	// ---------------------------------------------------------------
	// Wishbone slave
	// ---------------------------------------------------------------
	// Answer one cycle after the strobe; unmapped reads return zero
	wire wb_req  = wb_cyc_i && wb_stb_i && !ack_q;
	wire wb_wr   = wb_req && wb_we_i && wb_sel_i[0];
	wire wr_acc  = wb_wr && (wb_adr_i == mal_pkg::ADR_ACC);
	wire wr_flg  = wb_wr && (wb_adr_i == mal_pkg::ADR_FLAGS);
	wire wr_mop  = wb_wr && (wb_adr_i == mal_pkg::ADR_MULOP);
	wire ex_acc  = exec_now && (wr_mul || (wr_dst && !dst_mem_q));
	wire ex_flag = exec_now && (upd_z || upd_c || upd_hv);

	logic [31:0] rd_mux;

	// Read selection, narrow registers sit in the low byte except STATUS, whose op field sits in bits 8 to 12
	always_comb begin
		rd_mux = mal_pkg::WORD_ZERO;
		case (wb_adr_i)
			mal_pkg::ADR_ACC:    rd_mux[7:0] = acc_q;
			mal_pkg::ADR_FLAGS:  rd_mux[mal_pkg::FLG_W-1:0] = flags_q;
			mal_pkg::ADR_MULOP:  rd_mux[7:0] = mulop_q;
			mal_pkg::ADR_MULRH:  rd_mux[7:0] = mulrh_q;
			mal_pkg::ADR_STATUS: begin
				rd_mux[mal_pkg::STS_BUSY] = (state_q != mal_pkg::ST_IDLE);
				rd_mux[mal_pkg::STS_OP_LO +: 5] = op_q;
			end
			default: rd_mux = mal_pkg::WORD_ZERO;
		endcase
	end

	// Bus handshake
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q  <= 1'b0;
			rdat_q <= mal_pkg::WORD_ZERO;
		end else begin
			ack_q <= wb_req;
			if (wb_req) begin
				rdat_q <= rd_mux;
			end
		end
	end

	// ---------------------------------------------------------------
	// Architectural registers
	// ---------------------------------------------------------------
	// Execution wins over a software write in the same cycle,
	// so no hardware result is ever lost
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			acc_q   <= mal_pkg::RST_BYTE;
			mulop_q <= mal_pkg::RST_BYTE;
			mulrh_q <= mal_pkg::RST_BYTE;
		end else begin
			if (ex_acc) begin
				acc_q <= wr_mul ? product[7:0] : res;
			end else if (wr_acc) begin
				acc_q <= wb_dat_i[7:0];
			end
			if (exec_now && wr_mul) begin
				mulrh_q <= product[15:8];
			end
			if (wr_mop) begin
				mulop_q <= wb_dat_i[7:0];
			end
		end
	end

	// Flags update per field; untouched fields keep their value
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			flags_q <= mal_pkg::RST_FLAGS;
		end else if (ex_flag) begin
			if (upd_z) begin
				flags_q[mal_pkg::FLG_ZERO] <= z_new;
			end
			if (upd_c) begin
				flags_q[mal_pkg::FLG_CARRY] <= new_c;
			end
			if (upd_hv) begin
				flags_q[mal_pkg::FLG_HALF] <= ar[9];
				flags_q[mal_pkg::FLG_OVF]  <= ar[10];
			end
		end else if (wr_flg) begin
			flags_q <= wb_dat_i[mal_pkg::FLG_W-1:0];
		end
	end

	// ---------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------
	assign wb_ack_o     = ack_q;
	assign wb_dat_o     = rdat_q;
	assign exec_ready_o = (state_q == mal_pkg::ST_IDLE);
	assign exec_done_o  = done_q;
	assign mem_addr_o   = addr_q;
	assign mem_we_o     = (state_q == mal_pkg::ST_WRITE);
	assign mem_wdata_o  = wdata_q;
	assign io_we_o      = io_pend_q;
	assign io_wdata_o   = wdata_q;

endmodule : mal_alu

//--- verification/mal_alu_props.sv
`timescale 1ns/1ps
module mal_alu_props #(
	parameter int ADDR_W = 7
) (
	input wire logic              clk_i,
	input wire logic              rst_i,
	input wire logic              wb_stb_i,
	input wire logic              wb_cyc_i,
	input wire logic              wb_ack_o,
	input wire logic              exec_valid_i,
	input wire logic [4:0]        exec_op_i,
	input wire logic              exec_dst_mem_i,
	input wire logic              exec_ready_o,
	input wire logic              exec_done_o,
	input wire logic [ADDR_W-1:0] mem_addr_o,
	input wire logic [7:0]        mem_rdata_i,
	input wire logic              mem_we_o,
	input wire logic [7:0]        mem_wdata_o,
	input wire logic              io_we_o
);
	// ---------------------------------------------------------------
	// Request decode
	// ---------------------------------------------------------------
	wire tk = exec_valid_i & exec_ready_o;
	wire mw = tk & exec_dst_mem_i;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// ---------------------------------------------------------------
	// Properties
	// ---------------------------------------------------------------
	AST_ACK_LAT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
		|=> wb_ack_o ##1 !wb_ack_o) else $error("ack timing wrong");
	AST_ACC_DONE: assert property (
		tk && !exec_dst_mem_i |=> !exec_done_o ##1 exec_done_o)
		else $error("acc op done late");
	AST_MEM_SEQ: assert property (
		mw && exec_op_i == mal_pkg::OP_INC |=> !mem_we_o
		##1 mem_we_o && !exec_done_o ##1 exec_done_o && !mem_we_o)
		else $error("mem sequence wrong");
	AST_INC_VAL: assert property (
		mw && exec_op_i == mal_pkg::OP_INC
		|-> ##2 mem_wdata_o == $past(mem_rdata_i) + 8'h01)
		else $error("increment value wrong");
	AST_RSHIFT_VAL: assert property (
		mw && exec_op_i == mal_pkg::OP_SR
		|-> ##2 mem_wdata_o == ($past(mem_rdata_i) >> 1))
		else $error("right shift wrong");
	AST_LSHIFT_VAL: assert property (
		mw && exec_op_i == mal_pkg::OP_SL
		|-> ##2 mem_wdata_o == ($past(mem_rdata_i) << 1))
		else $error("left shift wrong");
	AST_NOT_VAL: assert property (
		mw && exec_op_i == mal_pkg::OP_NOT
		|-> ##2 mem_wdata_o == ~$past(mem_rdata_i))
		else $error("complement wrong");
	AST_CLR_VAL: assert property (
		mw && exec_op_i == mal_pkg::OP_CLR
		|-> ##2 mem_we_o && mem_wdata_o == 8'h00)
		else $error("clear wrong");
	AST_CMP_NOWR: assert property (
		tk && exec_op_i == mal_pkg::OP_CMP
		|=> (!mem_we_o && !io_we_o) [*2]) else $error("compare wrote");
	AST_ADDR_HOLD: assert property (
		mem_we_o |-> $stable(mem_addr_o)) else $error("addr moved");
	AST_XORIO: assert property (
		tk && exec_op_i == mal_pkg::OP_XORIO
		|=> ##1 io_we_o && exec_done_o) else $error("io write wrong");
	AST_BUSY: assert property (
		tk |=> !exec_ready_o) else $error("ready during op");
endmodule : mal_alu_props

bind mal_alu mal_alu_props #(.ADDR_W(ADDR_W)) u_props (.clk_i, .rst_i,
	.wb_stb_i, .wb_cyc_i, .wb_ack_o, .exec_valid_i, .exec_op_i,
	.exec_dst_mem_i, .exec_ready_o, .exec_done_o, .mem_addr_o,
	.mem_rdata_i, .mem_we_o, .mem_wdata_o, .io_we_o);

//--- verification/mal_mem_model.sv
`timescale 1ns/1ps
module mal_mem_model #(
	parameter int ADDR_W = 7
) (
	input wire logic              clk_i,
	input wire logic [ADDR_W-1:0] mem_addr_i,
	input wire logic              mem_we_i,
	input wire logic [7:0]        mem_wdata_i,
	input wire logic              io_we_i,
	input wire logic [7:0]        io_wdata_i,
	output logic     [7:0]        mem_rdata_o,
	output logic     [7:0]        io_rdata_o
);
	// Plain always: the bench preloads these arrays too
	logic [7:0] mem_q [2**ADDR_W];
	logic [7:0] io_q  [2**ADDR_W];
	assign mem_rdata_o = mem_q[mem_addr_i];
	assign io_rdata_o  = io_q[mem_addr_i];
	always @(posedge clk_i) begin
		if (mem_we_i)
			mem_q[mem_addr_i] <= mem_wdata_i;
		if (io_we_i)
			io_q[mem_addr_i] <= io_wdata_i;
	end
endmodule : mal_mem_model

//--- verification/mal_alu_tb_top.sv
`timescale 1ns/1ps
module mal_alu_tb_top;
	logic clk_i, rst_i, wb_we_i, wb_stb_i, wb_cyc_i, wb_ack_o, mem_we_o;
	logic exec_valid_i, exec_dst_mem_i, exec_src_imm_i, io_we_o;
	logic exec_ready_o, exec_done_o;
	logic [3:0] wb_sel_i;
	logic [4:0] exec_op_i, op;
	logic [6:0] exec_addr_i, mem_addr_o;
	logic [7:0] wb_adr_i, exec_imm_i, mem_rdata_i, mem_wdata_o;
	logic [7:0] io_rdata_i, io_wdata_o, mh_m;
	logic [31:0] wb_dat_i, wb_dat_o, rd;
	logic dm, im;
	int bad_count, num_checks, cycles, k;

	mal_alu #(.ADDR_W(7)) u_dut (.*);
	mal_mem_model #(.ADDR_W(7)) u_mem (.clk_i(clk_i),
		.mem_addr_i(mem_addr_o), .mem_we_i(mem_we_o),
		.mem_wdata_i(mem_wdata_o), .io_we_i(io_we_o),
		.io_wdata_i(io_wdata_o), .mem_rdata_o(mem_rdata_i),
		.io_rdata_o(io_rdata_i));

	initial begin
		clk_i = 1'h0;
		forever #10 clk_i = ~clk_i;
	end
	// Hang guard, well above the longest run
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 30000) begin
			bad_count++;
			summarize();
		end
	end

	task automatic summarize();
		if (bad_count == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : summarize

	task automatic chk(input string n, input logic [31:0] e,
		input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			bad_count++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask : chk

	// One classic cycle; read data left in rd
	task automatic wb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clk_i);
		wb_cyc_i <= 1'h1;
		wb_stb_i <= 1'h1;
		wb_we_i  <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_sel_i <= 4'hF;
		do @(posedge clk_i); while (wb_ack_o !== 1'h1);
		rd = wb_dat_o;
		wb_cyc_i <= 1'h0;
		wb_stb_i <= 1'h0;
	endtask : wb

	// Expected {flags, result}; borrows count as carry on subtract
	function automatic logic [11:0] ref_op(input logic [4:0] o,
		input logic [7:0] d, input logic [7:0] s, input logic [3:0] f);
		logic [7:0] a, b, r;
		logic [8:0] t;
		logic [4:0] h;
		logic ci, sb, ar;
		logic [3:0] nf;
		sb = o inside {mal_pkg::OP_SUB, mal_pkg::OP_SUBC,
			mal_pkg::OP_SUBC1, mal_pkg::OP_DEC, mal_pkg::OP_CMP};
		ar = sb | (o inside {mal_pkg::OP_ADD, mal_pkg::OP_ADDC,
			mal_pkg::OP_ADDC1, mal_pkg::OP_NADD, mal_pkg::OP_INC});
		a = (o == mal_pkg::OP_NADD) ? s : d;
		b = (o inside {mal_pkg::OP_ADDC1, mal_pkg::OP_SUBC1}) ? 8'h00 :
			(o inside {mal_pkg::OP_INC, mal_pkg::OP_DEC}) ? 8'h01 :
			(o == mal_pkg::OP_NADD) ? ~d : s;
		ci = (o inside {mal_pkg::OP_ADDC, mal_pkg::OP_ADDC1,
			mal_pkg::OP_SUBC, mal_pkg::OP_SUBC1}) ? f[1] :
			(o == mal_pkg::OP_NADD);
		b = sb ? ~b : b;
		ci = ci ^ sb;
		t = {1'h0, a} + {1'h0, b} + {8'h00, ci};
		h = {1'h0, a[3:0]} + {1'h0, b[3:0]} + {4'h0, ci};
		r = ar ? t[7:0] : d;
		nf = f;
		if (ar)
			nf = {(a[7] == b[7]) && (r[7] != a[7]), h[4] ^ sb, t[8] ^ sb,
				r == 8'h00};
		case (o)
			mal_pkg::OP_SR:    {r, nf[1]} = {1'h0, d};
			mal_pkg::OP_SRC:   {r, nf[1]} = {f[1], d};
			mal_pkg::OP_SL:    {nf[1], r} = {d, 1'h0};
			mal_pkg::OP_SLC:   {nf[1], r} = {d, f[1]};
			mal_pkg::OP_SWAP:  r = {d[3:0], d[7:4]};
			mal_pkg::OP_AND:   r = d & s;
			mal_pkg::OP_OR:    r = d | s;
			mal_pkg::OP_XOR,
			mal_pkg::OP_XORIO: r = d ^ s;
			mal_pkg::OP_NOT:   r = ~d;
			mal_pkg::OP_NEG:   r = -d;
			mal_pkg::OP_CLR:   r = 8'h00;
			default: ;
		endcase
		if (o inside {mal_pkg::OP_AND, mal_pkg::OP_OR, mal_pkg::OP_XOR,
			mal_pkg::OP_NOT, mal_pkg::OP_NEG})
			nf[0] = (r == 8'h00);
		return {nf, r};
	endfunction : ref_op

	// Load operands, execute one op, compare every result
	task automatic run(input logic [4:0] o, input logic m_d,
		input logic i_s, input logic [7:0] a, input logic [3:0] f,
		input logic [7:0] mo, input logic [7:0] m);
		logic [6:0] ad;
		logic [7:0] io, iv, d, s, ea, em, ei;
		logic [11:0] x;
		logic [15:0] p;
		ad = 7'($urandom);
		io = 8'($urandom);
		iv = 8'($urandom);
		wb(1'h1, mal_pkg::ADR_ACC, {24'h0, a});
		wb(1'h1, mal_pkg::ADR_FLAGS, {28'h0, f});
		wb(1'h1, mal_pkg::ADR_MULOP, {24'h0, mo});
		u_mem.mem_q[ad] = m;
		u_mem.io_q[ad] = io;
		d = (o == mal_pkg::OP_XORIO) ? io : m_d ? m : a;
		s = (m_d || o == mal_pkg::OP_XORIO) ? a : i_s ? iv : m;
		x = ref_op(o, d, s, f);
		p = {8'h00, a} * {8'h00, mo};
		ea = a;
		em = m;
		ei = io;
		if (o == mal_pkg::OP_MUL)
			{mh_m, ea} = p;
		else if (o == mal_pkg::OP_XORIO)
			ei = x[7:0];
		else if (o != mal_pkg::OP_CMP && m_d)
			em = x[7:0];
		else if (o != mal_pkg::OP_CMP)
			ea = x[7:0];
		@(posedge clk_i);
		exec_valid_i   <= 1'h1;
		exec_op_i      <= o;
		exec_dst_mem_i <= m_d;
		exec_src_imm_i <= i_s;
		exec_addr_i    <= ad;
		exec_imm_i     <= iv;
		do @(posedge clk_i); while (exec_ready_o !== 1'h1);
		exec_valid_i <= 1'h0;
		do @(posedge clk_i); while (exec_done_o !== 1'h1);
		wb(1'h0, mal_pkg::ADR_ACC, 32'h0);
		chk("acc", {24'h0, ea}, rd);
		wb(1'h0, mal_pkg::ADR_FLAGS, 32'h0);
		chk("flags", {28'h0, x[11:8]}, rd);
		wb(1'h0, mal_pkg::ADR_MULRH, 32'h0);
		chk("mulrh", {24'h0, mh_m}, rd);
		chk("mem", {24'h0, em}, {24'h0, u_mem.mem_q[ad]});
		chk("io", {24'h0, ei}, {24'h0, u_mem.io_q[ad]});
	endtask : run

	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial begin
		{rst_i, wb_we_i, wb_stb_i, wb_cyc_i, exec_valid_i} = 5'h10;
		{exec_dst_mem_i, exec_src_imm_i, wb_sel_i} = 6'h00;
		{exec_op_i, exec_addr_i, wb_adr_i, exec_imm_i} = 28'h0;
		wb_dat_i = 32'h0;
		{bad_count, num_checks, cycles} = {3{32'h0}};
		mh_m = 8'h00;
		void'($urandom(81));
		repeat (5) @(posedge clk_i);
		rst_i <= 1'h0;
		// Read-only and unmapped writes must leave zeros
		for (k = 3; k < 6; k++)
			wb(1'h1, 8'(k * 4), 32'h0000_00FF);
		for (k = 0; k < 6; k++) begin
			wb(1'h0, 8'(k * 4), 32'h0);
			// Status shows the idle latched op, all else reads zero
			chk("reset", (k == 4) ? {19'h0, mal_pkg::OP_CLR, 8'h00}
				: 32'h0, rd);
		end
		run(mal_pkg::OP_MUL, 1'h0, 1'h0, 8'hA5, 4'h5, 8'h5A, 8'h00);
		run(mal_pkg::OP_CMP, 1'h0, 1'h0, 8'h38, 4'h0, 8'h00, 8'h38);
		run(mal_pkg::OP_CMP, 1'h0, 1'h0, 8'h38, 4'h0, 8'h00, 8'h42);
		run(mal_pkg::OP_ADD, 1'h0, 1'h0, 8'h7F, 4'h0, 8'h00, 8'h01);
		run(mal_pkg::OP_SUBC, 1'h1, 1'h0, 8'h00, 4'h2, 8'h00, 8'h00);
		run(mal_pkg::OP_NEG, 1'h0, 1'h0, 8'h38, 4'hF, 8'h00, 8'h00);
		// Every op, both destinations except INC/DEC/CLR (memory only) and SWAP/MUL/XORIO (accumulator only), random data
		for (k = 0; k < 230; k++) begin
			op = 5'(k % 23);
			dm = 1'((k / 23) % 2);
			if (op inside {mal_pkg::OP_INC, mal_pkg::OP_DEC, mal_pkg::OP_CLR})
				dm = 1'h1;
			if (op inside {mal_pkg::OP_SWAP, mal_pkg::OP_MUL,
				mal_pkg::OP_XORIO})
				dm = 1'h0;
			im = !dm && 1'($urandom) && (op inside {mal_pkg::OP_ADD,
				mal_pkg::OP_SUB, mal_pkg::OP_AND, mal_pkg::OP_OR,
				mal_pkg::OP_XOR});
			run(op, dm, im, 8'($urandom), 4'($urandom), 8'($urandom),
				8'($urandom));
		end
		summarize();
	end
endmodule : mal_alu_tb_top
